/* rtl/rx_port_select_pkg.sv */
// package of constants and carriers for the receive port select and tag mux
package rx_port_select_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFF   = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] TAG_OFF    = 12'h008;

  localparam int CTRL_AUTO_BIT   = 0;
  localparam int CTRL_MANUAL_BIT = 1; // 1 = nibble port when auto is off
  localparam int CTRL_EAD_BIT    = 3; // ext_addr_detect_select
  localparam int CTRL_FDX_BIT    = 4;
  localparam int CTRL_TAG_BIT    = 14; // rx_tagging_enable_bit

  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;
  localparam int QUIET_TIME_NS   = 1000;
  localparam int QUIET_CYCLES    = (QUIET_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int SYNC_STAGES     = 2;

  typedef enum logic [1:0] {
    PORT_SERIAL = 2'b00,
    PORT_NIBBLE = 2'b01
  } port_e;

  typedef struct packed {
    logic tag_en;
    logic tag_d;
  } tag_bit_s;

endpackage

/* rtl/rx_port_select_tag_mux.sv */
// receive port selection, serial receive outputs and frame tag capture
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rx_port_select_tag_mux
  import rx_port_select_pkg::*;
#(
  parameter int TAG_WIDTH = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mdio_in,
  input  wire logic        rx_clk_in,
  input  wire logic        rx_data_in,
  input  wire logic        rx_en_in,
  input  wire logic        rxd0_in,
  input  wire logic        rx_dv_in,
  input  wire logic        srd_pin_in,
  input  wire logic        serial_rx_clock_out_pin_in,
  output logic             serial_rx_data_out,
  output logic             serial_rx_clock_out,
  output logic             serial_rx_oe,
  output logic             tag_valid,
  input  wire logic        tag_ready,
  output tag_bit_s         tag_bit,
  output logic             nibble_selected,
  output logic             full_duplex
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  // the tag register is read back as one bus word
  if (TAG_WIDTH < 1 || TAG_WIDTH > 32) begin : g_bad_width
    $error("TAG_WIDTH out of range");
  end

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic       tclk_d_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 6'h00;
      s2_ff <= 6'h00;
    end else begin
      s1_ff <= {serial_rx_clock_out_pin_in, srd_pin_in, rx_dv_in, rxd0_in,
                rx_clk_in, mdio_in};
      s2_ff <= s1_ff;
    end
  end

  logic mdio_s;
  logic rxclk_s;
  logic rxd0_s;
  logic rxdv_s;
  logic srd_s;
  logic serial_rx_clock_out_s;
  assign {serial_rx_clock_out_s, srd_s, rxdv_s, rxd0_s, rxclk_s, mdio_s} = s2_ff;

  logic [1:0] d1_ff;
  logic [1:0] d2_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_ff <= 2'h0;
      d2_ff <= 2'h0;
    end else begin
      d1_ff <= {rx_en_in, rx_data_in};
      d2_ff <= d1_ff;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic [31:0] tag_word_ff;
  logic        wr_en;
  logic        rd_en;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr != CTRL_OFF) &&
                   (paddr != STATUS_OFF) && (paddr != TAG_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_en && paddr == CTRL_OFF) begin
      ctrl_ff <= pwrite ? (pwdata & 32'h0000_401b) : ctrl_ff;
    end
  end

  logic auto_sel;
  logic tagging;
  assign auto_sel    = ctrl_ff[CTRL_AUTO_BIT];
  assign tagging     = ctrl_ff[CTRL_EAD_BIT] && ctrl_ff[CTRL_TAG_BIT];
  assign full_duplex = ctrl_ff[CTRL_FDX_BIT];

  // ------------------------------------------------------------------
  // port selection
  // ------------------------------------------------------------------
  // mdio must rest high for a whole quiet window before the nibble port
  // wins; a single sample would follow management traffic
  localparam int QW = $clog2(QUIET_CYCLES + 1);
  logic [QW-1:0] quiet_cnt_ff;
  port_e         port_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt_ff <= '0;
    end else if (!mdio_s) begin
      quiet_cnt_ff <= '0;
    end else if (quiet_cnt_ff != QW'(QUIET_CYCLES)) begin
      quiet_cnt_ff <= quiet_cnt_ff + QW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_ff <= PORT_SERIAL;
    end else if (auto_sel) begin
      if (quiet_cnt_ff == QW'(QUIET_CYCLES)) begin
        port_ff <= PORT_NIBBLE;
      end
    end else begin
      port_ff <= ctrl_ff[CTRL_MANUAL_BIT] ? PORT_NIBBLE : PORT_SERIAL;
    end
  end

  logic nib;
  assign nib             = (port_ff == PORT_NIBBLE);
  assign nibble_selected = nib;

  // ------------------------------------------------------------------
  // serial receive outputs
  // ------------------------------------------------------------------
  logic srd_ff;
  logic serial_rx_clock_out_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srd_ff    <= 1'b0;
      serial_rx_clock_out_ff <= 1'b0;
    end else if (nib) begin
      srd_ff    <= 1'b0;
      serial_rx_clock_out_ff <= 1'b0;
    end else begin
      srd_ff    <= d2_ff[0];
      serial_rx_clock_out_ff <= rxclk_s;
    end
  end
  assign serial_rx_data_out  = srd_ff;
  assign serial_rx_clock_out = serial_rx_clock_out_ff;
  assign serial_rx_oe        = !(nib && tagging);

  // ------------------------------------------------------------------
  // tag capture
  // ------------------------------------------------------------------
  logic tag_d_sel;
  logic tag_e_sel;
  logic tag_clk_sel;
  always_comb begin
    tag_d_sel   = 1'b0;
    tag_e_sel   = 1'b0;
    tag_clk_sel = 1'b0;
    if (tagging && nib) begin
      tag_d_sel   = srd_s;
      tag_e_sel   = serial_rx_clock_out_s;
      tag_clk_sel = rxclk_s;
    end else if (tagging) begin
      tag_d_sel   = rxd0_s;
      tag_e_sel   = rxdv_s;
      tag_clk_sel = rxclk_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_d_ff <= 1'b0;
    end else begin
      tclk_d_ff <= tag_clk_sel;
    end
  end

  logic tag_edge;
  assign tag_edge = tag_clk_sel && !tclk_d_ff && tag_e_sel;

  // two entry buffer between the sampler and the tag consumer; a bit that
  // meets a full buffer with no pop in that cycle is dropped, not stalled: the link cannot wait
  tag_bit_s buf_ff [2];
  logic [1:0] cnt_ff;
  logic       rd_ptr_ff;
  logic       wr_ptr_ff;
  logic       push;
  logic       pop;
  assign tag_valid = (cnt_ff != 2'd0);
  assign pop       = tag_valid && tag_ready;
  assign push      = tag_edge && (cnt_ff != 2'd2 || pop);
  assign tag_bit   = buf_ff[rd_ptr_ff];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      cnt_ff    <= 2'd0;
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
    end else begin
      if (push) begin
        buf_ff[wr_ptr_ff] <= '{tag_en: 1'b1, tag_d: tag_d_sel};
        wr_ptr_ff         <= !wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= !rd_ptr_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_word_ff <= 32'h0000_0000;
    end else if (push) begin
      tag_word_ff <= {tag_word_ff[30:0], tag_d_sel};
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        CTRL_OFF:   prdata = ctrl_ff;
        STATUS_OFF: prdata = {28'h0, tagging, cnt_ff == 2'd2, 1'b0, nib};
        TAG_OFF:    prdata = tag_word_ff & ((32'h1 << TAG_WIDTH) - 32'h1);
        default:    prdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  nib_data_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    nib ##1 nib |-> !serial_rx_data_out)
    else $error("serial data moves in nibble mode");
  nib_clk_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    nib ##1 nib |-> !serial_rx_clock_out)
    else $error("serial clock moves in nibble mode");
  serial_data_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !nib ##1 !nib |-> serial_rx_data_out == $past(d2_ff[0]))
    else $error("serial data not forwarded");
  serial_clk_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !nib ##1 !nib |-> serial_rx_clock_out == $past(rxclk_s))
    else $error("serial clock not forwarded");
  auto_pick_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    auto_sel && quiet_cnt_ff == QW'(QUIET_CYCLES) |=> nib)
    else $error("auto select missed nibble port");
  manual_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(auto_sel) && $past(nib) |-> nib)
    else $error("auto select chose serial port");
  tag_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tagging |-> !push)
    else $error("tag captured while disabled");
  pin_owner_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    serial_rx_oe != (nib && tagging))
    else $error("serial pin direction wrong");
  tag_src_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tagging && !nib |-> tag_d_sel == rxd0_s && tag_e_sel == rxdv_s)
    else $error("serial mode tag source wrong");
  tag_nib_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tagging && nib |-> tag_d_sel == srd_s && tag_e_sel == serial_rx_clock_out_s)
    else $error("nibble mode tag source wrong");
  oe_primary_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tagging |-> serial_rx_oe)
    else $error("serial pin taken while tagging off");
  tag_shift_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    push |=> tag_word_ff[0] == $past(tag_d_sel))
    else $error("tag bit not shifted in");
  tag_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    push |-> tagging && tag_e_sel)
    else $error("tag pushed without enable");
  buf_bound_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cnt_ff != 2'd3)
    else $error("tag buffer overflow");
  cover_push_c:    cover property (@(posedge pclk) push);
  cover_full_c:    cover property (@(posedge pclk) cnt_ff == 2'd2);
  cover_nib_c:     cover property (@(posedge pclk) !nib ##1 nib);
  cover_tag_nib_c: cover property (@(posedge pclk) tagging && nib && push);
  cover_drop_c:    cover property (@(posedge pclk) tag_edge && !push);

endmodule
`default_nettype wire

/* tb/far_end_model.sv */
// far-side transceiver and tag source model driving the receive pins
`timescale 1ns/100ps
`default_nettype none
module far_end_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic       nib,
  input  wire logic [7:0] bits,
  input  wire logic [7:0] mask,
  output logic            rx_clk_in,
  output logic            rx_data_in,
  output logic            rx_en_in,
  output logic            rxd0_in,
  output logic            rx_dv_in,
  output logic            srd_pin_in,
  output logic            serial_rx_clock_out_pin_in,
  output logic            busy
);
  logic [7:0] cnt;
  logic       tog;
  logic       d;
  logic       m;
  // ------------------------------------------------------------------
  // frame timing: 8 bit times of 32 cycles, 160 ns each
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt  <= 8'h00;
      tog  <= 1'b0;
    end else begin
      tog <= ~tog;
      if (go) begin
        busy <= 1'b1;
      end else if (busy) begin
        cnt <= cnt + 8'h01;
        if (cnt == 8'hff) begin
          busy <= 1'b0;
        end
      end
    end
  end
  assign d = bits[cnt[7:5]];
  assign m = mask[cnt[7:5]];
  // clock stands low between frames; released lines toggle, never hold
  assign rx_clk_in     = busy & cnt[4];
  assign rx_data_in    = busy ? d : tog;
  assign rx_en_in      = busy;
  assign rxd0_in       = (busy & !nib) ? d : tog;
  assign rx_dv_in      = nib ? tog : (busy & m);
  assign srd_pin_in    = (busy & nib) ? d : ~tog;
  assign serial_rx_clock_out_pin_in = nib ? (busy & m) : ~tog;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// top-level bench for the receive port select and tag mux
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top import rx_port_select_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, mdio_in = 1'b0, tag_ready = 1'b0;
  logic        go = 1'b0, nib = 1'b0, busy, e, pd, pc;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0]  bits = 8'h00, mask = 8'h00, exp_t, m;
  logic        rx_clk_in, rx_data_in, rx_en_in, rxd0_in, rx_dv_in;
  logic        srd_pin_in, serial_rx_clock_out_pin_in, pready, pslverr, tag_valid;
  logic        serial_rx_data_out, serial_rx_clock_out, serial_rx_oe;
  logic        nibble_selected, full_duplex;
  logic [2:0]  dh, ch;
  tag_bit_s    tag_bit;
  int          n_mismatch = 0, comparisons = 0, seed = 32'h89258b66;

  rx_port_select_tag_mux #(.TAG_WIDTH(8)) u_dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mdio_in,
    .rx_clk_in, .rx_data_in, .rx_en_in, .rxd0_in, .rx_dv_in, .srd_pin_in,
    .serial_rx_clock_out_pin_in, .serial_rx_data_out, .serial_rx_clock_out, .serial_rx_oe,
    .tag_valid, .tag_ready, .tag_bit, .nibble_selected, .full_duplex);
  far_end_model u_far (.pclk, .presetn, .go, .nib, .bits, .mask, .rx_clk_in,
    .rx_data_in, .rx_en_in, .rxd0_in, .rx_dv_in, .srd_pin_in, .serial_rx_clock_out_pin_in,
    .busy);

  initial begin
    forever #(CLK_PERIOD_NS / 2.0) pclk = ~pclk;
  end
  // ------------------------------------------------------------------
  // serial outputs lag the pins by two sync stages plus one register
  // ------------------------------------------------------------------
  always @(posedge pclk) begin
    if (busy && !nibble_selected) begin
      `CHK("srd", dh[2], serial_rx_data_out)
      `CHK("serial_rx_clock_out", ch[2], serial_rx_clock_out)
    end
    if (busy && nibble_selected) begin
      `CHK("srd_still", pd, serial_rx_data_out)
      `CHK("serial_rx_clock_out_still", pc, serial_rx_clock_out)
    end
    dh <= {dh[1:0], rx_data_in};
    ch <= {ch[1:0], rx_clk_in};
    pd <= serial_rx_data_out;
    pc <= serial_rx_clock_out;
  end

  function automatic logic [7:0] shift_tag(logic [7:0] p, logic [7:0] b,
                                           logic [7:0] k);
    for (int i = 0; i < 8; i++) begin
      if (k[i]) p = {p[6:0], b[i]};
    end
    return p;
  endfunction

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // answer and read data are taken at the edge that sees pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task frame(input logic nb, input logic [7:0] k, input logic t);
    logic [7:0]  b;
    b = 8'($random(seed));
    @(posedge pclk);
    nib  <= nb;
    mask <= k;
    bits <= b;
    go   <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do begin
      @(posedge pclk);
      #1;
    end while (busy === 1'b1);
    if (t) exp_t = shift_tag(exp_t, b, k);
  endtask

  task final_report;
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    final_report;
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    exp_t = 8'h00;
    apb(1'b0, CTRL_OFF, 32'h0);
    `CHK("ctrl_rst", CTRL_RESET, r)
    apb(1'b0, 12'h0f0, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_rd", 32'h0, r)
    frame(1'b0, 8'hff, 1'b0);
    `CHK("valid_off", 1'b0, tag_valid)
    apb(1'b0, TAG_OFF, 32'h0);
    `CHK("tag_off", 32'h0, r)
    apb(1'b1, CTRL_OFF, 32'h4009);
    tag_ready <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      m = (k == 0) ? 8'hff : 8'($random(seed));
      frame(1'b0, m, 1'b1);
      apb(1'b0, TAG_OFF, 32'h0);
      `CHK("tag_serial", {24'h0, exp_t}, r)
    end
    // third bit meets a full two-entry buffer and is lost
    tag_ready <= 1'b0;
    frame(1'b0, 8'h07, 1'b0);
    exp_t = shift_tag(exp_t, bits, 8'h03);
    apb(1'b0, STATUS_OFF, 32'h0);
    `CHK("buf_full", 1'b1, r[2])
    `CHK("status_tag", 1'b1, r[3])
    apb(1'b0, TAG_OFF, 32'h0);
    `CHK("tag_drop", {24'h0, exp_t}, r)
    for (int k = 0; k < 2; k++) begin
      #1;
      `CHK("buf_valid", 1'b1, tag_valid)
      `CHK("buf_en", 1'b1, tag_bit.tag_en)
      `CHK("buf_data", bits[k], tag_bit.tag_d)
      @(posedge pclk);
      tag_ready <= 1'b1;
      @(posedge pclk);
      tag_ready <= 1'b0;
    end
    #1;
    `CHK("buf_empty", 1'b0, tag_valid)
    mdio_in <= 1'b1;
    repeat (QUIET_CYCLES + 20) @(posedge pclk);
    #1;
    `CHK("auto_nibble", 1'b1, nibble_selected)
    `CHK("oe_nibble", 1'b0, serial_rx_oe)
    tag_ready <= 1'b1;
    frame(1'b1, 8'hff, 1'b1);
    apb(1'b0, TAG_OFF, 32'h0);
    `CHK("tag_nibble", {24'h0, exp_t}, r)
    apb(1'b1, CTRL_OFF, 32'h4018);
    repeat (2) @(posedge pclk);
    #1;
    `CHK("manual_serial", 1'b0, nibble_selected)
    `CHK("fdx", 1'b1, full_duplex)
    `CHK("oe_serial", 1'b1, serial_rx_oe)
    frame(1'b0, 8'hff, 1'b1);
    apb(1'b0, TAG_OFF, 32'h0);
    `CHK("tag_fdx", {24'h0, exp_t}, r)
    apb(1'b1, CTRL_OFF, 32'h0002);
    repeat (2) @(posedge pclk);
    #1;
    `CHK("manual_nibble", 1'b1, nibble_selected)
    `CHK("oe_notag", 1'b1, serial_rx_oe)
    frame(1'b1, 8'hff, 1'b0);
    apb(1'b0, TAG_OFF, 32'h0);
    `CHK("tag_notag", {24'h0, exp_t}, r)
    final_report;
  end
endmodule
`default_nettype wire
